// >>> src/sdc_control_regs.sv
`timescale 1ns/1ps
module sdc_control_regs (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Serial link pins
	input wire logic sck,
	input wire logic sdi,
	input wire logic serial_frame_select_n,
	output logic sdo,
	output logic sdo_oe,
	// Enable pin
	input wire logic enable_pin,
	// Fault events from protection logic (same clock)
	input wire logic [1:0] thermal_field,
	input wire logic undervoltage_flag,
	input wire logic rotor_halt_flag,
	input wire logic open_load_phase_a,
	input wire logic open_load_phase_b,
	input wire logic [7:0] overcurrent_flags,
	input wire logic pwm_on_phase_a,
	// Regulator settings
	output logic pwm_mode,
	output logic [2:0] off_interval,
	output logic [11:0] regulator_cycles,
	output logic [1:0] overcurrent_delay,
	output logic [7:0] overcurrent_cycles,
	output logic clock_source_ext,
	output logic [3:0] halt_count_margin,
	// Drive settings
	output logic bridge_enable,
	output logic [1:0] open_load_level,
	output logic [6:0] open_load_pct,
	output logic recirculation_side,
	output logic braking,
	output logic slew_enable,
	output logic [1:0] decay_select,
	// Monitor pin
	output logic monitor_pin,
	// Position and phase currents
	output logic [5:0] angle_readback,
	output logic [5:0] phase_a_mag,
	output logic phase_a_neg,
	output logic [5:0] phase_b_mag,
	output logic phase_b_neg
);
	typedef enum logic [0:0] {SDC_IDLE, SDC_FRAME} sdc_state_e;

	// Pin synchronisers: stage 0 feeds stage 1 only
	localparam int NPIN = 4;
	// Reset to idle levels so release makes no false strobe edge
	localparam logic [NPIN-1:0] PIN_IDLE = 4'h4;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync0_r;
	logic [NPIN-1:0] sync1_r;
	logic [NPIN-1:0] sync_d_r;
	assign pin_raw = {enable_pin, serial_frame_select_n, sdi, sck};

	genvar gp;
	generate
		for (gp = 0; gp < NPIN; gp++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					sync0_r[gp] <= PIN_IDLE[gp];
					sync1_r[gp] <= PIN_IDLE[gp];
					sync_d_r[gp] <= PIN_IDLE[gp];
				end else begin
					sync0_r[gp] <= pin_raw[gp];
					sync1_r[gp] <= sync0_r[gp];
					sync_d_r[gp] <= sync1_r[gp];
				end
			end
		end
	endgenerate

	// Edge detection on synchronised pins
	wire sck_s = sync1_r[0];
	wire sdi_s = sync1_r[1];
	wire frame_n_s = sync1_r[2];
	wire enable_s = sync1_r[3];
	wire sck_rise = sck_s & ~sync_d_r[0];
	wire sck_fall = ~sck_s & sync_d_r[0];
	wire frame_fall = ~frame_n_s & sync_d_r[2];
	wire frame_rise = frame_n_s & ~sync_d_r[2];

	// State and registers
	sdc_state_e state_r, state_nxt;
	logic [3:0] setup_a_r;
	logic [13:0] setup_b_r;
	logic [13:0] run_r;
	logic [5:0] angle_r;
	logic [4:0] prof_ptr_r;
	logic [14:0] flags_r;
	logic [7:0] oc_r;
	logic write_err_r;
	logic parity_err_r;
	logic [15:0] rx_r;
	logic [4:0] bit_cnt_r;
	logic sel_b_r;
	logic [15:0] snap_a_r;
	logic [15:0] snap_b_r;
	logic sdo_r;

	// Assembled diagnostic words
	wire fault_summary = (|flags_r) | (|oc_r) | write_err_r
		| parity_err_r;
	wire [15:0] monitor_pin_select_a = {fault_summary, flags_r[14:8], oc_r};
	wire [15:0] monitor_pin_select_b = {fault_summary, flags_r[14:8], 2'h0,
		angle_r};

	// Fresh events mapped into word A positions
	wire [14:0] ev_flags = {thermal_field, 1'b0, undervoltage_flag,
		rotor_halt_flag, open_load_phase_b, open_load_phase_a,
		8'h00};

	// Frame completion decode
	wire frame_end = (state_r == SDC_FRAME) & frame_rise;
	wire word_ok = frame_end & (bit_cnt_r == 5'h10);
	wire word_err = frame_end & (bit_cnt_r != 5'h10)
		& (bit_cnt_r != 5'h00);
	wire [1:0] wr_addr = rx_r[sdc_pkg::ADDR_HI:sdc_pkg::ADDR_LO];
	wire wr_setup_a = word_ok & (wr_addr == sdc_pkg::ADDR_SETUP_A);
	wire wr_setup_b = word_ok & (wr_addr == sdc_pkg::ADDR_SETUP_B);
	wire wr_run = word_ok & (wr_addr == sdc_pkg::ADDR_RUN);
	wire wr_prof = word_ok & (wr_addr == sdc_pkg::ADDR_PROFILE);
	wire prof_take = wr_prof & (prof_ptr_r < 5'h10);
	wire prof_bad = prof_take
		& ~(^rx_r[sdc_pkg::PROF_PARITY_BIT:0]);

	// Signed step change, wrapping within one electrical cycle
	wire [5:0] delta = rx_r[sdc_pkg::RUN_DELTA_LO +: 6];
	wire [5:0] angle_nxt = 6'(angle_r + delta);

	// Frame state machine
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SDC_IDLE: begin
				if (frame_fall) begin
					state_nxt = SDC_FRAME;
				end
			end
			SDC_FRAME: begin
				if (frame_rise) begin
					state_nxt = SDC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= SDC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Receive shifter and bit counter, data taken on rising SCK
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rx_r <= 16'h0000;
			bit_cnt_r <= 5'h00;
			sel_b_r <= 1'b0;
		end else if (frame_fall) begin
			bit_cnt_r <= 5'h00;
			sel_b_r <= 1'b0;
		end else if ((state_r == SDC_FRAME) && sck_rise) begin
			rx_r <= {rx_r[14:0], sdi_s};
			if (bit_cnt_r != 5'h1F) begin
				bit_cnt_r <= 5'(bit_cnt_r + 5'h01);
			end
			if (bit_cnt_r == 5'h01) begin
				sel_b_r <= ({rx_r[0], sdi_s} == sdc_pkg::ADDR_SETUP_B);
			end
		end
	end

	// Transmit: summary first, then the selected word MSB first
	// Bit 14 leaves before the address is known; both words share it
	wire [15:0] tx_word = sel_b_r ? snap_b_r : snap_a_r;
	wire [3:0] tx_idx = 4'(5'h0F - bit_cnt_r);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			snap_a_r <= 16'h0000;
			snap_b_r <= 16'h0000;
			sdo_r <= 1'b0;
		end else if (frame_fall) begin
			snap_a_r <= monitor_pin_select_a;
			snap_b_r <= monitor_pin_select_b;
			sdo_r <= fault_summary;
		end else if ((state_r == SDC_FRAME) && sck_fall
			&& (bit_cnt_r != 5'h00) && (bit_cnt_r < 5'h10)) begin
			sdo_r <= tx_word[tx_idx];
		end
	end

	assign sdo = sdo_r;
	assign sdo_oe = (state_r == SDC_FRAME);

	// Register writes by address
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			setup_a_r <= sdc_pkg::SA_RESET;
			setup_b_r <= sdc_pkg::SB_RESET;
			run_r <= sdc_pkg::RUN_RESET;
			angle_r <= 6'h00;
		end else begin
			if (wr_setup_a) begin
				setup_a_r <= rx_r[3:0];
			end
			if (wr_setup_b) begin
				setup_b_r <= rx_r[13:0];
			end
			if (wr_run) begin
				run_r <= rx_r[13:0];
				angle_r <= angle_nxt;
			end
		end
	end

	// Profile entry pointer
	// A poll frame with no clock rises is no write and keeps the pointer
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prof_ptr_r <= 5'h00;
		end else if (word_err || wr_setup_a || wr_setup_b || wr_run) begin
			prof_ptr_r <= 5'h00;
		end else if (prof_take) begin
			prof_ptr_r <= 5'(prof_ptr_r + 5'h01);
		end
	end

	// Diagnostic flags: sticky, cleared at frame end, new events win
	// An event in the clearing cycle must survive into the next readout
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_r <= sdc_pkg::DG_POWERON;
			oc_r <= 8'hFF;
			write_err_r <= 1'b0;
			parity_err_r <= 1'b0;
		end else begin
			flags_r <= (frame_end ? 15'h0000 : flags_r) | ev_flags;
			oc_r <= (frame_end ? 8'h00 : oc_r) | overcurrent_flags;
			write_err_r <= word_err | (write_err_r & ~frame_end);
			parity_err_r <= prof_bad | (parity_err_r & ~frame_end);
		end
	end

	// Field outputs
	assign pwm_mode = setup_a_r[sdc_pkg::SA_PWM_BIT];
	assign off_interval = setup_a_r[sdc_pkg::SA_OFF_LO +: 3];
	assign clock_source_ext = setup_b_r[sdc_pkg::SB_OSC_BIT];
	assign overcurrent_delay = setup_b_r[sdc_pkg::SB_OCD_LO +: 2];
	assign halt_count_margin = setup_b_r[sdc_pkg::SB_MARGIN_LO +: 4];
	assign open_load_level = run_r[sdc_pkg::RUN_OL_LO +: 2];
	assign recirculation_side = run_r[sdc_pkg::RUN_RECIRC_BIT];
	assign braking = run_r[sdc_pkg::RUN_BRAKE_BIT];
	assign slew_enable = run_r[sdc_pkg::RUN_SLEW_BIT];
	assign decay_select = run_r[sdc_pkg::RUN_DECAY_LO +: 2];
	assign angle_readback = angle_r;

	// Regulator timing in system clock cycles
	// Every code divides exactly at 50 MHz, so no rounding is needed
	wire [11:0] off_cyc = 12'((sdc_pkg::OFF_BASE_NS
		+ sdc_pkg::OFF_STEP_NS * int'(off_interval))
		/ sdc_pkg::CLK_PERIOD_NS);
	wire [11:0] per_cyc = 12'(sdc_pkg::PERIOD_NS[off_interval]
		/ sdc_pkg::CLK_PERIOD_NS);
	wire [7:0] ocd_cyc = 8'(sdc_pkg::OCD_NS[overcurrent_delay]
		/ sdc_pkg::CLK_PERIOD_NS);
	wire [6:0] ol_pct = 7'(sdc_pkg::OL_BASE_PCT
		+ sdc_pkg::OL_STEP_PCT * int'(open_load_level));

	// Monitor pin source selection
	// Temperature shows any nonzero thermal code, warnings included
	wire [1:0] mon_sel = setup_b_r[sdc_pkg::SB_MON_LO +: 2];
	wire temp_any = |thermal_field;
	wire mon_nxt = (mon_sel == sdc_pkg::MON_FAULT_N) ? ~fault_summary :
		(mon_sel == sdc_pkg::MON_HALT_N) ? ~rotor_halt_flag :
		(mon_sel == sdc_pkg::MON_PWM_A) ? pwm_on_phase_a :
		temp_any;

	// Bridge enable: register bit or pin
	wire bridge_nxt = run_r[sdc_pkg::RUN_EN_BIT] | enable_s;

	// Registered data outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			regulator_cycles <= 12'h000;
			overcurrent_cycles <= 8'h00;
			open_load_pct <= 7'h00;
			monitor_pin <= 1'b0;
			bridge_enable <= 1'b0;
		end else begin
			regulator_cycles <= pwm_mode ? per_cyc : off_cyc;
			overcurrent_cycles <= ocd_cyc;
			open_load_pct <= ol_pct;
			monitor_pin <= mon_nxt;
			bridge_enable <= bridge_nxt;
		end
	end

	// Phase current profile
	sdc_profile_table u_table (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_en(prof_take),
		.wr_index(prof_ptr_r[3:0]),
		.wr_value(rx_r[sdc_pkg::PROF_VALUE_LO +: 6]),
		.angle(angle_r),
		.phase_a_mag(phase_a_mag),
		.phase_a_neg(phase_a_neg),
		.phase_b_mag(phase_b_mag),
		.phase_b_neg(phase_b_neg)
	);
endmodule : sdc_control_regs

// >>> src/sdc_pkg.sv
package sdc_pkg;
	// Clock and timing base
	localparam int CLK_PERIOD_NS = 20;
	localparam int SYNC_STAGES = 2;
	localparam int WORD_BITS = 16;
	localparam int ANGLE_BITS = 6;
	localparam int PROFILE_ENTRIES = 16;

	// Serial word layout
	localparam int ADDR_HI = 15;
	localparam int ADDR_LO = 14;
	localparam logic [1:0] ADDR_SETUP_A = 2'h0;
	localparam logic [1:0] ADDR_SETUP_B = 2'h1;
	localparam logic [1:0] ADDR_RUN = 2'h2;
	localparam logic [1:0] ADDR_PROFILE = 2'h3;

	// Setup register A (only the regulator timing bits are kept)
	localparam int SA_PWM_BIT = 0;
	localparam int SA_OFF_LO = 1;
	localparam logic [3:0] SA_RESET = 4'h2;

	// Setup register B fields
	localparam int SB_OSC_BIT = 13;
	localparam int SB_OCD_LO = 11;
	localparam int SB_MARGIN_LO = 2;
	localparam int SB_MON_LO = 0;
	localparam logic [13:0] SB_RESET = 14'h1020;

	// Run register fields
	localparam int RUN_EN_BIT = 13;
	localparam int RUN_OL_LO = 11;
	localparam int RUN_RECIRC_BIT = 10;
	localparam int RUN_SLEW_BIT = 9;
	localparam int RUN_BRAKE_BIT = 8;
	localparam int RUN_DECAY_LO = 6;
	localparam int RUN_DELTA_LO = 0;
	localparam logic [13:0] RUN_RESET = 14'h0A80;

	// Profile load word
	localparam int PROF_PARITY_BIT = 6;
	localparam int PROF_VALUE_LO = 0;

	// Diagnostic word layout
	localparam int DG_SUMMARY_BIT = 15;
	localparam int DG_THERM_LO = 13;
	localparam int DG_RSVD_BIT = 12;
	localparam int DG_UV_BIT = 11;
	localparam int DG_HALT_BIT = 10;
	localparam int DG_OLB_BIT = 9;
	localparam int DG_OLA_BIT = 8;
	localparam logic [14:0] DG_POWERON = 15'h7FFF;

	// Monitor pin selections
	localparam logic [1:0] MON_FAULT_N = 2'h0;
	localparam logic [1:0] MON_HALT_N = 2'h1;
	localparam logic [1:0] MON_PWM_A = 2'h2;
	localparam logic [1:0] MON_TEMP = 2'h3;

	// Regulator times in ns and open load percentages per code
	localparam int OFF_BASE_NS = 20000;
	localparam int OFF_STEP_NS = 4000;
	localparam int PERIOD_NS [8] = '{24000, 32000, 40000, 46000,
		52000, 56000, 60000, 64000};
	localparam int OCD_NS [4] = '{500, 1000, 2000, 3000};
	localparam int OL_BASE_PCT = 20;
	localparam int OL_STEP_PCT = 10;

	// Default phase profile entry (plain ramp, full table reloadable)
	function automatic logic [5:0] sdc_default_profile(input int idx);
		sdc_default_profile = 6'((idx * 4) + 3);
	endfunction : sdc_default_profile
endpackage : sdc_pkg

// >>> src/sdc_profile_table.sv
`timescale 1ns/1ps
module sdc_profile_table (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Entry write
	input wire logic wr_en,
	input wire logic [3:0] wr_index,
	input wire logic [5:0] wr_value,
	// Position in, phase currents out
	input wire logic [5:0] angle,
	output logic [5:0] phase_a_mag,
	output logic phase_a_neg,
	output logic [5:0] phase_b_mag,
	output logic phase_b_neg
);
	logic [5:0] entry_r [sdc_pkg::PROFILE_ENTRIES];
	logic [5:0] angle_b;
	logic [5:0] mag_a;
	logic [5:0] mag_b;

	// Quadrant fold: each entry serves four angles (entry 15 only two), 0/32 stay at zero
	function automatic logic [5:0] fold_mag(input logic [5:0] ang,
		input logic [5:0] tbl [sdc_pkg::PROFILE_ENTRIES]);
		logic [4:0] q;
		q = ang[4:0];
		if (q == 5'h00) begin
			fold_mag = 6'h00;
		end else if (q <= 5'h10) begin
			fold_mag = tbl[4'(q - 5'h01)];
		end else begin
			fold_mag = tbl[4'(5'h1F - q)];
		end
	endfunction : fold_mag

	// Phase B leads A by a quarter cycle
	assign angle_b = 6'(angle + 6'h10);
	assign mag_a = fold_mag(angle, entry_r);
	assign mag_b = fold_mag(angle_b, entry_r);

	// Table storage, one entry per write
	genvar gi;
	generate
		for (gi = 0; gi < sdc_pkg::PROFILE_ENTRIES; gi++) begin : g_ent
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					entry_r[gi] <= sdc_pkg::sdc_default_profile(gi);
				end else if (wr_en && (wr_index == 4'(gi))) begin
					entry_r[gi] <= wr_value;
				end
			end
		end
	endgenerate

	// Registered phase outputs
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			phase_a_mag <= 6'h00;
			phase_a_neg <= 1'b0;
			phase_b_mag <= 6'h00;
			phase_b_neg <= 1'b0;
		end else begin
			phase_a_mag <= mag_a;
			phase_a_neg <= angle[5];
			phase_b_mag <= mag_b;
			phase_b_neg <= angle_b[5];
		end
	end
endmodule : sdc_profile_table

// >>> test/sdc_assertions.sv
`timescale 1ns/1ps
module sdc_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Serial link and enable
	input wire logic serial_frame_select_n,
	input wire logic sdo_oe,
	input wire logic enable_pin,
	input wire logic bridge_enable,
	// Settings and derived counts
	input wire logic pwm_mode,
	input wire logic [2:0] off_interval,
	input wire logic [11:0] regulator_cycles,
	input wire logic [1:0] overcurrent_delay,
	input wire logic [7:0] overcurrent_cycles,
	input wire logic [1:0] open_load_level,
	input wire logic [6:0] open_load_pct,
	// Position and phase A current
	input wire logic [5:0] angle_readback,
	input wire logic [5:0] phase_a_mag,
	input wire logic phase_a_neg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Frame opening and a settled idle line
	sequence frame_open;
		$fell(serial_frame_select_n);
	endsequence
	sequence line_idle;
		serial_frame_select_n [*5];
	endsequence
	// Counts follow fields that held still for a cycle after reset settled
	sequence held_fields;
		$stable({pwm_mode, off_interval, overcurrent_delay, open_load_level})
			&& $past(rst_n, 2);
	endsequence
	a_oe_start: assert property (frame_open |-> ##[1:4] sdo_oe)
		else $error("output not enabled after frame start");
	a_oe_release: assert property (line_idle |-> !sdo_oe)
		else $error("output still enabled on idle line");
	a_oe_hold: assert property (sdo_oe && !serial_frame_select_n
		|=> sdo_oe)
		else $error("output dropped inside frame");
	a_bridge_pin: assert property (enable_pin [*5] |-> bridge_enable)
		else $error("bridges off with enable pin high");
	a_off_time: assert property (held_fields and !pwm_mode |->
		regulator_cycles == 12'((sdc_pkg::OFF_BASE_NS + sdc_pkg::OFF_STEP_NS
		* off_interval) / sdc_pkg::CLK_PERIOD_NS))
		else $error("off time count wrong");
	a_freq_period: assert property (held_fields and pwm_mode |->
		regulator_cycles == 12'(sdc_pkg::PERIOD_NS[off_interval]
		/ sdc_pkg::CLK_PERIOD_NS))
		else $error("period count wrong");
	a_ocd_time: assert property (held_fields |->
		overcurrent_cycles == 8'(sdc_pkg::OCD_NS[overcurrent_delay]
		/ sdc_pkg::CLK_PERIOD_NS))
		else $error("overcurrent delay count wrong");
	a_ol_pct: assert property (held_fields |->
		open_load_pct == 7'(20 + 10 * open_load_level))
		else $error("open load percentage wrong");
	a_angle_hold: assert property (!sdo_oe && !$past(sdo_oe) |->
		$stable(angle_readback))
		else $error("angle moved outside a write");
	a_zero_phase: assert property (angle_readback[4:0] == 5'h00
		&& $stable(angle_readback) |-> phase_a_mag == 6'h00
		&& phase_a_neg == angle_readback[5])
		else $error("phase A not zero at its null angles");
endmodule : sdc_assertions

bind sdc_control_regs sdc_assertions u_chk (.sys_clk, .rst_n,
	.serial_frame_select_n, .sdo_oe, .enable_pin, .bridge_enable, .pwm_mode,
	.off_interval, .regulator_cycles, .overcurrent_delay, .overcurrent_cycles,
	.open_load_level, .open_load_pct, .angle_readback, .phase_a_mag,
	.phase_a_neg);

// >>> test/sdc_host_model.sv
`timescale 1ns/1ps
module sdc_host_model (
	// Clock
	input wire logic sys_clk,
	// Serial link
	output logic sck,
	output logic sdi,
	output logic serial_frame_select_n,
	input wire logic sdo,
	input wire logic sdo_oe
);
	// Link idles with the clock still and the strobe high
	initial begin
		sck = 1'b0;
		sdi = 1'b1;
		serial_frame_select_n = 1'b1;
	end
	// One framed word, n clock rises, 160 ns clock period
	// No step input exists here, so frames need no step spacing
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] rd);
		rd = 16'h0000;
		@(negedge sys_clk) serial_frame_select_n = 1'b0;
		repeat (4) @(negedge sys_clk);
		for (int i = 0; i < n; i++) begin
			sdi = w[15 - (i % 16)];
			repeat (4) @(negedge sys_clk);
			rd = {rd[14:0], sdo & sdo_oe};
			sck = 1'b1;
			repeat (4) @(negedge sys_clk);
			sck = 1'b0;
		end
		repeat (4) @(negedge sys_clk);
		serial_frame_select_n = 1'b1;
		sdi = ~sdi; // Released line does not keep its last bit
		repeat (8) @(negedge sys_clk);
	endtask : xfer
endmodule : sdc_host_model

// >>> test/test_stepper_driver_control_registers.sv
`timescale 1ns/1ps
module test_stepper_driver_control_registers;
	logic sys_clk, rst_n, sck, sdi, serial_frame_select_n, enable_pin;
	logic sdo, sdo_oe, undervoltage_flag, rotor_halt_flag, pwm_mode;
	logic open_load_phase_a, open_load_phase_b, pwm_on_phase_a, braking;
	logic [1:0] thermal_field, overcurrent_delay, open_load_level;
	logic [1:0] decay_select;
	logic [7:0] overcurrent_flags, overcurrent_cycles;
	logic clock_source_ext, bridge_enable, recirculation_side, slew_enable;
	logic monitor_pin, phase_a_neg, phase_b_neg;
	logic [2:0] off_interval;
	logic [11:0] regulator_cycles;
	logic [3:0] halt_count_margin;
	logic [6:0] open_load_pct;
	logic [5:0] angle_readback, phase_a_mag, phase_b_mag, ang, v;
	logic [15:0] rd;
	logic [5:0] pt [16];
	logic [5:0] dl [4];
	int checked, miscompares;
	// Packed views of field groups
	wire [15:0] setup_vec = {4'h0, monitor_pin, pwm_mode, off_interval,
		overcurrent_delay, clock_source_ext, halt_count_margin};
	wire [15:0] run_vec = {2'h0, bridge_enable, open_load_level,
		recirculation_side, slew_enable, braking, decay_select, angle_readback};
	wire [15:0] phase_vec = {2'h0, phase_a_neg, phase_a_mag, phase_b_neg,
		phase_b_mag};

	sdc_control_regs uut (.sys_clk, .rst_n, .sck, .sdi,
		.serial_frame_select_n, .sdo, .sdo_oe, .enable_pin, .thermal_field,
		.undervoltage_flag, .rotor_halt_flag, .open_load_phase_a,
		.open_load_phase_b, .overcurrent_flags, .pwm_on_phase_a, .pwm_mode,
		.off_interval, .regulator_cycles, .overcurrent_delay,
		.overcurrent_cycles, .clock_source_ext, .halt_count_margin,
		.bridge_enable, .open_load_level, .open_load_pct, .recirculation_side,
		.braking, .slew_enable, .decay_select, .monitor_pin, .angle_readback,
		.phase_a_mag, .phase_a_neg, .phase_b_mag, .phase_b_neg);
	sdc_host_model host (.sys_clk, .sck, .sdi, .serial_frame_select_n,
		.sdo, .sdo_oe);

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Fault inputs laid out as in diagnostic word A
	task automatic set_flt(input logic [15:0] f);
		thermal_field = f[14:13];
		{undervoltage_flag, rotor_halt_flag} = f[11:10];
		{open_load_phase_b, open_load_phase_a} = f[9:8];
		overcurrent_flags = f[7:0];
	endtask : set_flt
	// Magnitude for a quadrant position; null at 0 and 32
	function automatic logic [5:0] pm(input int q);
		q = q % 32;
		return (q == 0) ? 6'h00 : pt[(q <= 16) ? q - 1 : 31 - q];
	endfunction : pm
	task automatic end_of_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// 50 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Watchdog: 51 frames of up to 145 cycles, with ample margin
	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		enable_pin = 1'b0;
		pwm_on_phase_a = 1'b0;
		set_flt(16'h0000);
		ang = 6'h00;
		dl = '{6'h05, 6'h3D, 6'h1F, 6'h20};
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		chk("setup", 16'h00C8, setup_vec);
		chk("run", 16'h0A80, run_vec);
		chk("regulator_cycles", 16'h04B0, 16'(regulator_cycles));
		chk("overcurrent_cycles", 16'h0064, 16'(overcurrent_cycles));
		chk("open_load_pct", 16'h001E, 16'(open_load_pct));
		host.xfer(16'h000E, 16, rd);
		chk("power-on word", 16'hFFFF, rd);
		// Every off-time and period code
		for (int m = 0; m < 2; m++)
			for (int c = 0; c < 8; c++) begin
				host.xfer({12'h000, 3'(c), 1'(m)}, 16, rd);
				chk("cleared word", 16'h0000, rd);
				chk("regulator_cycles", 16'(m ? sdc_pkg::PERIOD_NS[c] / 20 :
					(20000 + 4000 * c) / 20), 16'(regulator_cycles));
			end
		// Setup B codes with the monitor pin source
		for (int i = 0; i < 4; i++) begin
			pwm_on_phase_a = 1'(i);
			host.xfer({2'b01, 1'(i), 2'(i), 5'h00, 4'(i * 5), 2'(i)}, 16,
				rd);
			chk("setup b", 16'({1'(i), 2'(i), 4'(i * 5), 1'(i < 2)}),
				16'({clock_source_ext, overcurrent_delay, halt_count_margin,
				monitor_pin}));
			chk("overcurrent_cycles", 16'(sdc_pkg::OCD_NS[i] / 20),
				16'(overcurrent_cycles));
		end
		// Run fields, enable pin and signed steps
		for (int i = 0; i < 4; i++) begin
			enable_pin = (i == 2);
			host.xfer({2'b10, 1'(i), 2'(i), 1'(i), ~1'(i), 1'(i >> 1), 2'(i),
				dl[i]}, 16, rd);
			ang = ang + dl[i];
			chk("run", 16'({1'(i) | (i == 2), 2'(i), 1'(i), ~1'(i),
				1'(i >> 1), 2'(i), ang}), run_vec);
			chk("open_load_pct", 16'(20 + 10 * i), 16'(open_load_pct));
		end
		// Table load, one even parity entry, a seventeenth write ignored
		for (int k = 0; k < 17; k++) begin
			v = 6'(63 - 3 * k);
			if (k < 16)
				pt[k] = v;
			host.xfer({9'h180, (k == 5) ^ ~(^v), v}, 16, rd);
			if (k == 6)
				chk("parity flag", 16'h0001, 16'(rd[15]));
		end
		dl = '{6'h00, 6'h20, 6'h1F, 6'h10};
		for (int j = 0; j < 4; j++) begin
			host.xfer({10'h200, dl[j]}, 16, rd);
			ang = ang + dl[j];
			chk("phase", 16'({ang >= 32, pm(ang), ang >= 16 && ang < 48,
				pm(ang + 16)}), phase_vec);
		end
		// Diagnostic words with faults held through the frames
		set_flt(16'h4DA5);
		host.xfer(16'h0002, 16, rd);
		chk("monitor_pin_select a", 16'hCDA5, rd);
		host.xfer(16'h5020, 16, rd);
		chk("monitor_pin_select b", 16'hCD10, rd);
		set_flt(16'h0000);
		// Short frame is refused and flagged
		host.xfer(16'h0002, 16, rd);
		host.xfer(16'h000E, 8, rd);
		chk("regulator_cycles", 16'h04B0, 16'(regulator_cycles));
		host.xfer(16'h0002, 16, rd);
		chk("error word", 16'h8000, rd);
		end_of_test();
	end
endmodule : test_stepper_driver_control_registers
